/* hdl/ssso_exec.sv */
// What this block does
// - left shift: count is low 8 bits of reg or imm, zero when above 31
// - arithmetic right shift fills with sign, count is low 8 bits of reg or imm
// - logical right shift fills with zeros, count is low 8 bits of reg or imm
// - true select: condition set picks first register, else second or immediate
// - false select: condition clear picks first register, else second or immediate
// - store address is base register plus sign-extended immediate, 32-bit unsigned
// - byte store: breakpoint, then control-space violation, then checked 8-bit write
// - half store: same checks and order, then checked 16-bit write, alignment fault
// - word store: control space gives checked control write, else 32-bit memory write
// - subtract writes second register minus first register, no exception
// - shift, select, subtract results available next cycle, any slot
// - syllable bit 27 clear selects register form, set selects immediate
// - 9-bit short immediate is sign-extended before use
`timescale 1ns/1ps
module ssso_exec
   import ssso_pkg::*;
(
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 sys_rst,
   // operation request
   input  wire ssso_pkg::ssso_req_s  req,
   // memory-side check results for the store address
   input  wire logic                 bkpt_hit,
   input  wire logic                 creg_space,
   input  wire logic                 creg_mapped,
   input  wire logic                 tlb_fault,
   // results
   output      ssso_pkg::ssso_wb_s   wb,
   output      ssso_pkg::ssso_st_s   st,
   output      ssso_pkg::ssso_exc_s  exc
);
   import ssso_pkg::*;

   logic                 is_imm;
   logic [SSSO_XLEN-1:0] imm_sx;
   logic [SSSO_XLEN-1:0] opnd2;
   logic [SSSO_CNT_W-1:0]cnt;
   logic [SSSO_XLEN-1:0] ea;
   logic                 is_store;
   logic                 misalign;
   ssso_wb_s             nxt_wb;
   ssso_st_s             nxt_st;
   ssso_exc_s            nxt_exc;
   ssso_wb_s             wb_ff;
   ssso_st_s             st_ff;
   ssso_exc_s            exc_ff;

   always_comb
   begin
      is_imm = req.syllable[SSSO_FMT_BIT];
      imm_sx = {{(SSSO_XLEN-SSSO_IMM_W){req.syllable[SSSO_IMM_LSB+SSSO_IMM_W-1]}},
                req.syllable[SSSO_IMM_LSB +: SSSO_IMM_W]};
      opnd2  = is_imm ? imm_sx : req.second_operand_register;
      cnt    = opnd2[SSSO_CNT_W-1:0];
      ea     = req.first_operand_register + imm_sx;
      is_store = (req.op == SSSO_OP_STB) || (req.op == SSSO_OP_STH) || (req.op == SSSO_OP_STW);
      misalign = ((req.op == SSSO_OP_STH) && ea[0]) || ((req.op == SSSO_OP_STW) && (ea[1:0] != '0));
   end

   always_comb
   begin
      nxt_wb  = '0;
      nxt_st  = '0;
      nxt_exc = '0;
      if (req.valid)
      begin
         case (req.op)
            SSSO_OP_SHL:
            begin
               nxt_wb.valid = 1'b1;
               nxt_wb.data  = (cnt > SSSO_CNT_W'(SSSO_MAX_SHIFT)) ? '0 : (req.first_operand_register << cnt);
            end
            SSSO_OP_SHR:
            begin
               nxt_wb.valid = 1'b1;
               nxt_wb.data  = (cnt > SSSO_CNT_W'(SSSO_MAX_SHIFT)) ? {SSSO_XLEN{req.first_operand_register[SSSO_XLEN-1]}}
                                                                 : SSSO_XLEN'($signed(req.first_operand_register) >>> cnt);
            end
            SSSO_OP_SHRU:
            begin
               nxt_wb.valid = 1'b1;
               nxt_wb.data  = (cnt > SSSO_CNT_W'(SSSO_MAX_SHIFT)) ? '0 : (req.first_operand_register >> cnt);
            end
            SSSO_OP_SLCT:
            begin
               nxt_wb.valid = 1'b1;
               nxt_wb.data  = req.cond ? req.first_operand_register : opnd2;
            end
            SSSO_OP_SLCTF:
            begin
               nxt_wb.valid = 1'b1;
               nxt_wb.data  = !req.cond ? req.first_operand_register : opnd2;
            end
            SSSO_OP_SUB:
            begin
               nxt_wb.valid = 1'b1;
               nxt_wb.data  = req.second_operand_register - req.first_operand_register;
            end
            SSSO_OP_STB, SSSO_OP_STH, SSSO_OP_STW:
            begin
               if (bkpt_hit)
                  nxt_exc.data_breakpoint_exception = 1'b1;
               else if (creg_space && (req.op != SSSO_OP_STW))
                  nxt_exc.control_space_violation = 1'b1;
               else if (misalign)
                  nxt_exc.alignment_fault = 1'b1;
               else if (creg_space && !creg_mapped)
                  nxt_exc.control_space_unmapped = 1'b1;
               else if (!creg_space && tlb_fault)
                  nxt_exc.data_translation_fault = 1'b1;
               else
               begin
                  nxt_st.valid = 1'b1;
                  nxt_st.addr  = ea;
                  nxt_st.data  = req.second_operand_register;
                  nxt_st.creg  = creg_space;
                  nxt_st.size  = (req.op == SSSO_OP_STB) ? SSSO_SIZE_BYTE :
                                 (req.op == SSSO_OP_STH) ? SSSO_SIZE_HALF : SSSO_SIZE_WORD;
               end
            end
            default:
            begin
               nxt_wb.valid = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         wb_ff  <= '0;
         st_ff  <= '0;
         exc_ff <= '0;
      end
      else
      begin
         wb_ff  <= nxt_wb;
         st_ff  <= nxt_st;
         exc_ff <= nxt_exc;
      end
   end

   assign wb  = wb_ff;
   assign st  = st_ff;
   assign exc = exc_ff;

   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   // store group never yields both a write and an exception
   sequence s_store_req;
      req.valid && is_store;
   endsequence

   sequence s_no_op;
      !req.valid || !(req.op inside {SSSO_OP_SHL, SSSO_OP_SHR, SSSO_OP_SHRU, SSSO_OP_SLCT, SSSO_OP_SLCTF,
                                     SSSO_OP_STB, SSSO_OP_STH, SSSO_OP_STW, SSSO_OP_SUB});
   endsequence

   a_shl_big_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (req.valid && req.op == SSSO_OP_SHL && cnt > SSSO_CNT_W'(SSSO_MAX_SHIFT)) |=> (wb.valid && wb.data == '0))
      else $error("left shift above 31 not zero");
   a_shr_sign_fill: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (req.valid && req.op == SSSO_OP_SHR && cnt > SSSO_CNT_W'(SSSO_MAX_SHIFT))
      |=> (wb.data == {SSSO_XLEN{$past(req.first_operand_register[SSSO_XLEN-1])}}))
      else $error("arith shift not sign filled");
   a_shru_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (req.valid && req.op == SSSO_OP_SHRU && cnt > SSSO_CNT_W'(SSSO_MAX_SHIFT)) |=> (wb.data == '0))
      else $error("logical shift not zero");
   a_slct_true: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (req.valid && req.op == SSSO_OP_SLCT && req.cond) |=> (wb.data == $past(req.first_operand_register)))
      else $error("true select wrong operand");
   a_slctf_false: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (req.valid && req.op == SSSO_OP_SLCTF && !req.cond) |=> (wb.data == $past(req.first_operand_register)))
      else $error("false select wrong operand");
   a_store_addr: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_store_req |=> (!st.valid || st.addr == $past(ea)))
      else $error("store address wrong");
   a_bkpt_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (s_store_req and bkpt_hit) |=> (exc.data_breakpoint_exception && !st.valid && !exc.control_space_violation))
      else $error("breakpoint not first");
   a_creg_viol: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (req.valid && req.op != SSSO_OP_STW && is_store && !bkpt_hit && creg_space) |=> exc.control_space_violation)
      else $error("control space not refused");
   a_word_creg: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (req.valid && req.op == SSSO_OP_STW && !bkpt_hit && creg_space && creg_mapped && !misalign)
      |=> (st.valid && st.creg))
      else $error("control write missing");
   a_sub_value: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (req.valid && req.op == SSSO_OP_SUB) |=> (wb.data == $past(req.second_operand_register) - $past(req.first_operand_register) && exc == '0))
      else $error("subtract wrong");
   a_wb_latency: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (req.valid && req.op inside {SSSO_OP_SHL, SSSO_OP_SUB, SSSO_OP_SLCT}) |=> wb.valid)
      else $error("result late");
   a_imm_format: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (req.valid && req.op == SSSO_OP_SLCT && !req.cond && is_imm)
      |=> (wb.data == {{(SSSO_XLEN-SSSO_IMM_W){$past(req.syllable[SSSO_IMM_LSB+SSSO_IMM_W-1])}},
                       $past(req.syllable[SSSO_IMM_LSB +: SSSO_IMM_W])}))
      else $error("immediate form wrong");

   // per-operation value and priority checks
   a_shl_value: assert property (
      (req.valid && req.op == SSSO_OP_SHL && cnt <= SSSO_CNT_W'(SSSO_MAX_SHIFT))
      |=> (wb.valid && wb.data == ($past(req.first_operand_register) << $past(cnt)))) else $error("left shift value wrong");

   a_shr_value: assert property (
      (req.valid && req.op == SSSO_OP_SHR && cnt <= SSSO_CNT_W'(SSSO_MAX_SHIFT))
      |=> (wb.data == SSSO_XLEN'($signed($past(req.first_operand_register)) >>> $past(cnt)))) else $error("arith shift wrong");

   a_shru_value: assert property (
      (req.valid && req.op == SSSO_OP_SHRU && cnt <= SSSO_CNT_W'(SSSO_MAX_SHIFT))
      |=> (wb.data == ($past(req.first_operand_register) >> $past(cnt)))) else $error("logical shift wrong");

   a_shr_big_valid: assert property (
      (req.valid && req.op == SSSO_OP_SHR && cnt > SSSO_CNT_W'(SSSO_MAX_SHIFT))
      |=> wb.valid) else $error("arith shift result missing");

   a_shru_big_valid: assert property (
      (req.valid && req.op == SSSO_OP_SHRU && cnt > SSSO_CNT_W'(SSSO_MAX_SHIFT))
      |=> (wb.valid && exc == '0)) else $error("logical shift result missing");

   a_slct_other: assert property (
      (req.valid && req.op == SSSO_OP_SLCT && !req.cond)
      |=> (wb.valid && wb.data == $past(opnd2))) else $error("true select second operand wrong");

   a_slctf_other: assert property (
      (req.valid && req.op == SSSO_OP_SLCTF && req.cond)
      |=> (wb.valid && wb.data == $past(opnd2))) else $error("false select second operand wrong");

   a_reg_form: assert property (
      (req.valid && req.op == SSSO_OP_SLCT && !req.cond && !is_imm)
      |=> (wb.data == $past(req.second_operand_register))) else $error("register form wrong");

   a_store_data: assert property (
      s_store_req |=> (!st.valid || st.data == $past(req.second_operand_register))) else $error("store data wrong");

   a_store_no_wb: assert property (
      s_store_req |=> !wb.valid) else $error("store wrote a register");

   a_byte_size: assert property (
      (req.valid && req.op == SSSO_OP_STB)
      |=> (!st.valid || (st.size == SSSO_SIZE_BYTE && !st.creg))) else $error("byte store size wrong");

   a_half_size: assert property (
      (req.valid && req.op == SSSO_OP_STH)
      |=> (!st.valid || (st.size == SSSO_SIZE_HALF && !st.creg))) else $error("half store size wrong");

   a_word_size: assert property (
      (req.valid && req.op == SSSO_OP_STW)
      |=> (!st.valid || st.size == SSSO_SIZE_WORD)) else $error("word store size wrong");

   a_half_align: assert property (
      (req.valid && req.op == SSSO_OP_STH && !bkpt_hit && !creg_space && ea[0])
      |=> (exc.alignment_fault && !st.valid)) else $error("half misalignment missed");

   a_word_align: assert property (
      (req.valid && req.op == SSSO_OP_STW && !bkpt_hit && misalign)
      |=> (exc.alignment_fault && !st.valid)) else $error("word misalignment missed");

   a_word_unmapped: assert property (
      (req.valid && req.op == SSSO_OP_STW && !bkpt_hit && creg_space && !creg_mapped && !misalign)
      |=> (exc.control_space_unmapped && !st.valid)) else $error("unmapped control write missed");

   a_mem_tlb: assert property (
      (s_store_req ##0 (!bkpt_hit && !creg_space && !misalign && tlb_fault))
      |=> (exc.data_translation_fault && !st.valid)) else $error("translation fault missed");

   a_mem_write: assert property (
      (s_store_req ##0 (!bkpt_hit && !creg_space && !misalign && !tlb_fault))
      |=> (st.valid && !st.creg && exc == '0)) else $error("memory write missing");

   a_exc_onehot: assert property (
      $onehot0(exc)) else $error("more than one exception");

   a_exc_or_store: assert property (
      !(st.valid && exc != '0)) else $error("store and exception together");

   a_one_kind: assert property (
      !(wb.valid && (st.valid || exc != '0))) else $error("result and store together");

   a_idle_quiet: assert property (
      s_no_op |=> (wb == '0 && st == '0 && exc == '0)) else $error("output without operation");

   a_sub_valid: assert property (
      (req.valid && req.op == SSSO_OP_SUB) |=> (wb.valid && !st.valid)) else $error("subtract result missing");

   a_alu_no_exc: assert property (
      (req.valid && req.op inside {SSSO_OP_SHR, SSSO_OP_SHRU, SSSO_OP_SLCTF})
      |=> (wb.valid && exc == '0)) else $error("shift or select result late");

   a_bkpt_word: assert property (
      (req.valid && req.op == SSSO_OP_STW && bkpt_hit)
      |=> (exc.data_breakpoint_exception && !st.valid)) else $error("word breakpoint missed");

   a_bkpt_half: assert property (
      (req.valid && req.op == SSSO_OP_STH && bkpt_hit)
      |=> (exc.data_breakpoint_exception && !exc.alignment_fault)) else $error("half breakpoint missed");
endmodule

/* hdl/ssso_pkg.sv */
package ssso_pkg;

   localparam int unsigned SSSO_XLEN      = 32;
   localparam int unsigned SSSO_IMM_W     = 9;
   localparam int unsigned SSSO_CNT_W     = 8;
   localparam int unsigned SSSO_SYL_W     = 32;
   localparam int unsigned SSSO_FMT_BIT   = 27;
   localparam int unsigned SSSO_IMM_LSB   = 12;
   localparam int unsigned SSSO_MAX_SHIFT = 31;

   localparam logic [1:0] SSSO_SIZE_BYTE = 2'h0;
   localparam logic [1:0] SSSO_SIZE_HALF = 2'h1;
   localparam logic [1:0] SSSO_SIZE_WORD = 2'h2;

   typedef enum logic [3:0]
   {
      SSSO_OP_NONE  = 4'h0,
      SSSO_OP_SHL   = 4'h1,
      SSSO_OP_SHR   = 4'h2,
      SSSO_OP_SHRU  = 4'h3,
      SSSO_OP_SLCT  = 4'h4,
      SSSO_OP_SLCTF = 4'h5,
      SSSO_OP_STB   = 4'h6,
      SSSO_OP_STH   = 4'h7,
      SSSO_OP_STW   = 4'h8,
      SSSO_OP_SUB   = 4'h9
   } ssso_op_e;

   typedef struct packed
   {
      logic                  valid;
      ssso_op_e              op;
      logic [SSSO_SYL_W-1:0] syllable;
      logic [SSSO_XLEN-1:0]  first_operand_register;
      logic [SSSO_XLEN-1:0]  second_operand_register;
      logic                  cond;
   } ssso_req_s;

   typedef struct packed
   {
      logic                 valid;
      logic [SSSO_XLEN-1:0] data;
   } ssso_wb_s;

   typedef struct packed
   {
      logic                 valid;
      logic [1:0]           size;
      logic                 creg;
      logic [SSSO_XLEN-1:0] addr;
      logic [SSSO_XLEN-1:0] data;
   } ssso_st_s;

   typedef struct packed
   {
      logic data_breakpoint_exception;
      logic control_space_violation;
      logic control_space_unmapped;
      logic data_translation_fault;
      logic alignment_fault;
   } ssso_exc_s;

endpackage

/* test/shift_select_store_sub_ops_test.sv */
`timescale 1ns/1ps
module shift_select_store_sub_ops_test;
   import ssso_pkg::*;
   logic        clk_sys;
   logic        sys_rst;
   ssso_req_s   req;
   logic [31:0] bkpt_addr;
   logic        bkpt_hit, creg_space, creg_mapped, tlb_fault;
   ssso_wb_s    wb;
   ssso_st_s    st;
   ssso_exc_s   exc;
   int          n_mismatch;
   int          comparisons;

   ssso_exec i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .bkpt_hit(bkpt_hit),
      .creg_space(creg_space), .creg_mapped(creg_mapped), .tlb_fault(tlb_fault), .wb(wb), .st(st), .exc(exc));
   ssso_mem_model i_mem (.req(req), .bkpt_addr(bkpt_addr), .bkpt_hit(bkpt_hit), .creg_space(creg_space),
      .creg_mapped(creg_mapped), .tlb_fault(tlb_fault));

   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [135:0] seen, input logic [135:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic issue(input ssso_op_e op, input logic fmt, input logic [8:0] imm, input logic [31:0] s1,
                        input logic [31:0] s2, input logic c);
      req = '{1'b1, op, {4'h0, fmt, 6'h0, imm, 12'h0}, s1, s2, c};
      @(posedge clk_sys);
      #1;
   endtask

   task automatic alu(input ssso_op_e op, input logic fmt, input logic [8:0] imm, input logic [31:0] s1,
                      input logic [31:0] s2, input logic c, input logic [31:0] exp);
      issue(op, fmt, imm, s1, s2, c);
      chk({wb, st.valid, exc}, {1'b1, exp, 6'h0});
   endtask

   task automatic t_shift();
      logic [8:0]  cnt [5] = '{9'h000, 9'h001, 9'h01F, 9'h020, 9'h1FF};
      logic [31:0] a = 32'h8000_00F1;
      logic [7:0]  k;
      foreach (cnt[i])
      begin
         k = cnt[i][7:0];
         alu(SSSO_OP_SHL, 1'b1, cnt[i], a, 32'h7, 1'b0, (k > 31) ? 32'h0 : a << k);
         alu(SSSO_OP_SHR, 1'b0, 9'h0, a, {24'h1, k}, 1'b0, $signed(a) >>> k);
         alu(SSSO_OP_SHR, 1'b1, cnt[i], a, 32'h7, 1'b0, $signed(a) >>> k);
         alu(SSSO_OP_SHRU, 1'b0, 9'h0, a, {24'h3, k}, 1'b0, a >> k);
         alu(SSSO_OP_SHRU, 1'b1, cnt[i], ~a, 32'h7, 1'b0, ~a >> k);
      end
      $display("shift test done");
   endtask

   task automatic t_select();
      for (int m = 0; m < 8; m++)
      begin
         alu(m[2] ? SSSO_OP_SLCTF : SSSO_OP_SLCT, m[1], 9'h180, 32'h1111_1111, 32'h2222_2222, m[0],
             (m[0] ^ m[2]) ? 32'h1111_1111 : (m[1] ? 32'hFFFF_FF80 : 32'h2222_2222));
      end
      $display("select test done");
   endtask

   task automatic sto(input ssso_op_e op, input logic [31:0] s1, input logic [8:0] imm, input logic [31:0] bk,
                      input logic [4:0] e, input logic cr);
      logic [31:0] ea;
      ea = s1 + {{23{imm[8]}}, imm};
      bkpt_addr = bk;
      issue(op, 1'b0, imm, s1, 32'hA5C3_9617, 1'b0);
      if (e != 5'h0)
         chk({st.valid, exc, wb.valid}, {1'b0, e, 1'b0});
      else
         chk({st, exc, wb.valid}, {1'b1, 2'(op - SSSO_OP_STB), cr, ea, 32'hA5C3_9617, 6'h0});
   endtask

   task automatic t_store();
      sto(SSSO_OP_STB, 32'h1000, 9'h003, 32'h0, 5'h00, 1'b0);
      sto(SSSO_OP_STB, 32'hFF00_0000, 9'h0, 32'h0, 5'h08, 1'b0);
      sto(SSSO_OP_STB, 32'hFF00_0000, 9'h0, 32'hFF00_0000, 5'h10, 1'b0);
      sto(SSSO_OP_STB, 32'hE000_0000, 9'h0, 32'h0, 5'h02, 1'b0);
      sto(SSSO_OP_STH, 32'h1000, 9'h001, 32'h0, 5'h01, 1'b0);
      sto(SSSO_OP_STH, 32'hFF00_0001, 9'h0, 32'h0, 5'h08, 1'b0);
      sto(SSSO_OP_STH, 32'h1000, 9'h1FE, 32'h0, 5'h00, 1'b0);
      sto(SSSO_OP_STH, 32'hE000_0002, 9'h0, 32'h0, 5'h02, 1'b0);
      sto(SSSO_OP_STW, 32'hFF00_0010, 9'h0, 32'h0, 5'h00, 1'b1);
      sto(SSSO_OP_STW, 32'hFF00_0F00, 9'h0, 32'h0, 5'h04, 1'b0);
      sto(SSSO_OP_STW, 32'hFF00_0F02, 9'h0, 32'h0, 5'h01, 1'b0);
      sto(SSSO_OP_STW, 32'hE000_0000, 9'h0, 32'h0, 5'h02, 1'b0);
      sto(SSSO_OP_STW, 32'hFF00_0010, 9'h0, 32'hFF00_0010, 5'h10, 1'b0);
      sto(SSSO_OP_STW, 32'h2000, 9'h1FC, 32'h0, 5'h00, 1'b0);
      $display("store test done");
   endtask

   task automatic t_sub();
      alu(SSSO_OP_SUB, 1'b0, 9'h0, 32'h3, 32'hA, 1'b0, 32'h7);
      alu(SSSO_OP_SHL, 1'b1, 9'h004, 32'h1, 32'h0, 1'b0, 32'h10);
      alu(SSSO_OP_SUB, 1'b0, 9'h0, 32'h1, 32'h8000_0000, 1'b0, 32'h7FFF_FFFF);
      alu(SSSO_OP_SUB, 1'b0, 9'h0, 32'h5, 32'h2, 1'b0, 32'hFFFF_FFFD);
      issue(SSSO_OP_NONE, 1'b0, 9'h0, 32'h5, 32'h2, 1'b0);
      chk({wb.valid, st.valid, exc}, 7'h00);
      $display("subtract test done");
   endtask

   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      #20000;
      n_mismatch++;
      stop_test();
   end

   initial
   begin
      n_mismatch = 0;
      comparisons = 0;
      sys_rst = 1'b1;
      req = '0;
      bkpt_addr = 32'h0;
      repeat (10) @(posedge clk_sys);
      #1;
      chk({wb, st, exc}, 136'h0);
      sys_rst = 1'b0;
      @(posedge clk_sys);
      #1;
      t_shift();
      t_select();
      t_store();
      t_sub();
      stop_test();
   end
endmodule

/* test/ssso_mem_model.sv */
`timescale 1ns/1ps
module ssso_mem_model
   import ssso_pkg::*;
(
   // request under way
   input  wire ssso_pkg::ssso_req_s req,
   input  wire logic [31:0]         bkpt_addr,
   // checks on the store address
   output logic                     bkpt_hit,
   output logic                     creg_space,
   output logic                     creg_mapped,
   output logic                     tlb_fault
);
   logic [31:0] ea;
   logic        is_st;

   // checks answer only while a store is on the port
   always_comb
   begin
      is_st       = req.valid && (req.op inside {SSSO_OP_STB, SSSO_OP_STH, SSSO_OP_STW});
      ea          = req.first_operand_register + {{23{req.syllable[20]}}, req.syllable[20:12]};
      bkpt_hit    = is_st && (ea == bkpt_addr);
      creg_space  = is_st && (ea[31:24] == 8'hFF);
      creg_mapped = is_st && (ea[11:8] != 4'hF);
      tlb_fault   = is_st && (ea[31:28] == 4'hE);
   end
endmodule
